// File: mam_pkg.sv
// package for the memory address mux: constants, modes and carriers
package mam_pkg;

  // ************************************************************
  // widths and field positions
  // ************************************************************
  localparam int ADDR_W      = 22;
  localparam int IADDR_W     = 26;
  localparam int SD_ADDR_W   = 13;
  localparam int BANK_HI_BIT = 21;
  localparam int BANK_LO_BIT = 20;
  localparam int MASK_W      = 4;
  localparam int COL_MIN     = 8;
  localparam int COL_SEL_W   = 2;

  localparam logic [ADDR_W-1:0]  ADDR_ZERO = 22'h00_0000;
  localparam logic [MASK_W-1:0]  MASK_ALL  = 4'hf;
  localparam logic [1:0]         SHIFT_8   = 2'h0;
  localparam logic [1:0]         SHIFT_16  = 2'h1;
  localparam logic [1:0]         SHIFT_32  = 2'h2;

  // ************************************************************
  // cycle kinds and widths
  // ************************************************************
  typedef enum logic [1:0] {
    MAM_W8  = 2'h0,
    MAM_W16 = 2'h1,
    MAM_W32 = 2'h2
  } mam_width_type;

  typedef enum logic [1:0] {
    MAM_CYC_SDRAM = 2'h0,
    MAM_CYC_MEM   = 2'h1,
    MAM_CYC_IO    = 2'h2
  } mam_cycle_type;

  // one request from the memory controller core
  typedef struct packed {
    mam_cycle_type        cycle;
    mam_width_type        width;
    logic                 col_phase;   // 1: column address, 0: row address
    logic [1:0]           bank;
    logic [IADDR_W-1:0]   addr;        // internal byte address
    logic [MASK_W-1:0]    lane_en;     // byte lanes in use
  } mam_req_type;

endpackage : mam_pkg

// File: mam_memory_address_mux.sv
// memory address mux: external address, bank select, byte masks, clock out
// How it works
// - top address pins: bits 21/20 or bank
// - 22-bit shared external address bus
// - row and column derived from internal address
// - column width programmable 8 to 11 bits
// - sdram address low 13, bank top two
// - io cycles show full byte address, memory cycles the width-shifted address
// - width shift for sdram and memory banks
// - no width shift for external io banks
// - system clock driven out on pin
// - separate sdram clock input accepted
// - four byte masks, one per data lane
`timescale 1ns/100ps
module mam_memory_address_mux (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           sdram_clock_in,
  input  wire logic                           req_valid,
  input  wire mam_pkg::mam_req_type           req,
  input  wire logic [mam_pkg::COL_SEL_W-1:0]  col_bits_sel,
  input  wire logic                           external_wait_n,
  output logic                                system_clock_out,
  output logic                                sdram_clock_seen,
  output logic [mam_pkg::ADDR_W-1:0]          addr_out,
  output logic                                bank_select_hi,
  output logic                                bank_select_lo,
  output logic [mam_pkg::MASK_W-1:0]          byte_lane_mask,
  output logic                                access_busy,
  output logic                                wait_active
);

  // ************************************************************
  // helper functions
  // ************************************************************
  // amount of shift for an access width
  function automatic logic [1:0] width_shift(input mam_pkg::mam_width_type w);
    logic [1:0] s;
    s = mam_pkg::SHIFT_8;
    unique case (w)
      mam_pkg::MAM_W8:  s = mam_pkg::SHIFT_8;
      mam_pkg::MAM_W16: s = mam_pkg::SHIFT_16;
      mam_pkg::MAM_W32: s = mam_pkg::SHIFT_32;
      default:          s = mam_pkg::SHIFT_8;
    endcase
    return s;
  endfunction : width_shift

  // word address after width adjustment
  function automatic logic [mam_pkg::IADDR_W-1:0] word_addr(
    input logic [mam_pkg::IADDR_W-1:0] a,
    input mam_pkg::mam_width_type      w);
    return a >> width_shift(w);
  endfunction : word_addr

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [2:0] wait_sync_r;
  logic [2:0] wait_sync_nxt;
  logic       wait_n_r;
  logic       wait_n_nxt;
  logic [2:0] sck_sync_r;
  logic [2:0] sck_sync_nxt;
  logic       sck_r;
  logic       sck_nxt;
  logic       sck_seen_r;
  logic       sck_seen_nxt;

  // three-stage sampling, change taken when stages two and three agree
  always_comb
  begin
    wait_sync_nxt = {wait_sync_r[1:0], external_wait_n};
    sck_sync_nxt  = {sck_sync_r[1:0], sdram_clock_in};
    wait_n_nxt    = wait_n_r;
    sck_nxt       = sck_r;
    if (wait_sync_r[2] == wait_sync_r[1])
    begin
      wait_n_nxt = wait_sync_r[2];
    end
    if (sck_sync_r[2] == sck_sync_r[1])
    begin
      sck_nxt = sck_sync_r[2];
    end
    sck_seen_nxt = sck_seen_r | (sck_nxt & ~sck_r);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wait_sync_r <= 3'h7;
      wait_n_r    <= 1'b1;
      sck_sync_r  <= 3'h0;
      sck_r       <= 1'b0;
      sck_seen_r  <= 1'b0;
    end
    else
    begin
      wait_sync_r <= wait_sync_nxt;
      wait_n_r    <= wait_n_nxt;
      sck_sync_r  <= sck_sync_nxt;
      sck_r       <= sck_nxt;
      sck_seen_r  <= sck_seen_nxt;
    end
  end

  // ************************************************************
  // address generation
  // ************************************************************
  logic [mam_pkg::ADDR_W-1:0] addr_r;
  logic [mam_pkg::ADDR_W-1:0] addr_nxt;
  logic [mam_pkg::MASK_W-1:0] mask_r;
  logic [mam_pkg::MASK_W-1:0] mask_nxt;
  logic                       busy_r;
  logic                       busy_nxt;
  logic [mam_pkg::IADDR_W-1:0] wa;
  logic [mam_pkg::IADDR_W-1:0] row_full;
  logic [3:0]                  col_w;
  logic [mam_pkg::SD_ADDR_W-1:0] col_mask;
  logic                        hold;

  always_comb
  begin
    // width shift for sdram and memory banks
    wa       = word_addr(req.addr, req.width);
    col_w    = 4'(mam_pkg::COL_MIN) + 4'(col_bits_sel);
    col_mask = mam_pkg::SD_ADDR_W'((1 << col_w) - 1);
    // row taken above the column bits
    row_full = wa >> col_w;
    hold     = busy_r & ~wait_n_r;
    addr_nxt = addr_r;
    mask_nxt = mask_r;
    busy_nxt = 1'b0;
    // hold address while wait stretches the access
    if (hold)
    begin
      busy_nxt = 1'b1;
    end
    else if (req_valid)
    begin
      addr_nxt = mam_pkg::ADDR_ZERO;
      mask_nxt = mam_pkg::MASK_ALL;
      unique case (req.cycle)
        mam_pkg::MAM_CYC_SDRAM:
        begin
          // row or column low, bank at top
          if (req.col_phase)
          begin
            addr_nxt[mam_pkg::SD_ADDR_W-1:0] = wa[mam_pkg::SD_ADDR_W-1:0] & col_mask;
          end
          else
          begin
            addr_nxt[mam_pkg::SD_ADDR_W-1:0] = row_full[mam_pkg::SD_ADDR_W-1:0];
          end
          // bank select on top two pins
          addr_nxt[mam_pkg::BANK_HI_BIT] = req.bank[1];
          addr_nxt[mam_pkg::BANK_LO_BIT] = req.bank[0];
          mask_nxt = ~req.lane_en;
        end
        mam_pkg::MAM_CYC_MEM:
        begin
          addr_nxt = wa[mam_pkg::ADDR_W-1:0];
          busy_nxt = 1'b1;
        end
        mam_pkg::MAM_CYC_IO:
        begin
          // raw byte address, board wiring selects lines
          addr_nxt = req.addr[mam_pkg::ADDR_W-1:0];
          busy_nxt = 1'b1;
        end
        default:
        begin
          addr_nxt = addr_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_r <= mam_pkg::ADDR_ZERO;
      mask_r <= mam_pkg::MASK_ALL;
      busy_r <= 1'b0;
    end
    else
    begin
      addr_r <= addr_nxt;
      mask_r <= mask_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // system clock driven out
  assign system_clock_out = clk;
  assign sdram_clock_seen = sck_seen_r;
  assign addr_out       = addr_r;
  assign bank_select_hi = addr_r[mam_pkg::BANK_HI_BIT];
  assign bank_select_lo = addr_r[mam_pkg::BANK_LO_BIT];
  assign byte_lane_mask = mask_r;
  assign access_busy    = busy_r;
  assign wait_active    = busy_r & ~wait_n_r;

  // ************************************************************
  // checks
  // ************************************************************
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      (busy_r && !wait_n_r) |=> $stable(addr_r) && busy_r;
  endproperty
  a_hold: assert property (p_hold) else $error("address moved during wait");

  property p_bank;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !hold && req.cycle == mam_pkg::MAM_CYC_SDRAM)
        |=> {bank_select_hi, bank_select_lo} == $past(req.bank);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");

  property p_io;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !hold && req.cycle == mam_pkg::MAM_CYC_IO)
        |=> addr_out == $past(req.addr[mam_pkg::ADDR_W-1:0]);
  endproperty
  a_io: assert property (p_io) else $error("io address adjusted");

  property p_mem;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !hold && req.cycle == mam_pkg::MAM_CYC_MEM && req.width == mam_pkg::MAM_W32)
        |=> addr_out == $past(req.addr[mam_pkg::ADDR_W+1:2]);
  endproperty
  a_mem: assert property (p_mem) else $error("memory address not shifted");

  property p_col;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !hold && req.cycle == mam_pkg::MAM_CYC_SDRAM && req.col_phase
       && col_bits_sel == 2'h0 && req.width == mam_pkg::MAM_W8)
        |=> addr_out[mam_pkg::SD_ADDR_W-1:0] == 13'(($past(req.addr)) & 26'h00_00ff);
  endproperty
  a_col: assert property (p_col) else $error("column address wrong");

  property p_row;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !hold && req.cycle == mam_pkg::MAM_CYC_SDRAM && !req.col_phase
       && col_bits_sel == 2'h3 && req.width == mam_pkg::MAM_W8)
        |=> addr_out[mam_pkg::SD_ADDR_W-1:0] == 13'($past(req.addr) >> 11);
  endproperty
  a_row: assert property (p_row) else $error("row address wrong");

  property p_mid;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !hold && req.cycle == mam_pkg::MAM_CYC_SDRAM)
        |=> addr_out[19:13] == 7'h00;
  endproperty
  a_mid: assert property (p_mid) else $error("unused sdram pins driven");

  property p_mask;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && !hold && req.cycle == mam_pkg::MAM_CYC_SDRAM)
        |=> byte_lane_mask == ~$past(req.lane_en);
  endproperty
  a_mask: assert property (p_mask) else $error("byte mask wrong");

  // busy must drop once wait is gone and no new async access is taken
  property p_wait;
    @(posedge clk) disable iff (!rst_n)
      (!wait_active && !(req_valid && (req.cycle == mam_pkg::MAM_CYC_MEM
       || req.cycle == mam_pkg::MAM_CYC_IO))) |=> !access_busy;
  endproperty
  a_wait: assert property (p_wait) else $error("access outlived the wait");

endmodule : mam_memory_address_mux

// File: mam_ext_dev.sv
// partner model: slow device wait line and board clock loop
`timescale 1ns/100ps
module mam_ext_dev (
  input  wire logic clk,
  input  wire logic system_clock_out,
  input  wire logic hold_wait,
  output logic      sdram_clock_in = 1'b0,
  output logic      external_wait_n = 1'b1
);
  // ************************************************************
  // board clock loop and slow device
  // ************************************************************
  // clock out returns delayed, at quarter rate
  // a same-rate loop would always be sampled at one level
  logic loop_ph = 1'b0;
  always @(posedge system_clock_out)
  begin
    loop_ph <= ~loop_ph;
    if (loop_ph)
      sdram_clock_in <= #3 ~sdram_clock_in;
  end
  always_ff @(posedge clk) external_wait_n <= !hold_wait;
endmodule : mam_ext_dev

// File: testbench.sv
// testbench for the memory address mux
`timescale 1ns/100ps
module testbench;
  logic                 clk, rst_n, req_valid, hold_wait, sys_clk, sd_clk, wait_n;
  logic                 seen, busy, wact, bhi, blo;
  logic [1:0]           col_bits_sel;
  logic [21:0]          addr;
  logic [3:0]           mask;
  mam_pkg::mam_req_type req;
  int                   errors, comparisons;
  localparam logic [25:0] A1 = 26'h3a5_c3e7;
  localparam logic [25:0] A2 = 26'h1b6_9d52;

  mam_memory_address_mux mam_memory_address_mux_i (.clk(clk), .rst_n(rst_n),
    .sdram_clock_in(sd_clk), .req_valid(req_valid), .req(req),
    .col_bits_sel(col_bits_sel), .external_wait_n(wait_n), .system_clock_out(sys_clk),
    .sdram_clock_seen(seen), .addr_out(addr), .bank_select_hi(bhi),
    .bank_select_lo(blo), .byte_lane_mask(mask), .access_busy(busy), .wait_active(wact));
  mam_ext_dev mam_ext_dev_i (.clk(clk), .system_clock_out(sys_clk), .hold_wait(hold_wait),
    .sdram_clock_in(sd_clk), .external_wait_n(wait_n));

  // ************************************************************
  // clock, compare and request helpers
  // ************************************************************
  // free running system clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare and count
  task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    if (s !== e)
      errors++;
  endtask : check

  // one request, outputs settled on return
  task automatic send(input mam_pkg::mam_cycle_type c, input int w, input logic ph,
                      input logic [1:0] bk, input logic [25:0] a, input logic [3:0] ln);
    @(posedge clk);
    #1 req_valid = 1'b1;
    req = '{cycle: c, width: mam_pkg::mam_width_type'(w), col_phase: ph, bank: bk,
            addr: a, lane_en: ln};
    @(posedge clk);
    #1 req_valid = 1'b0;
  endtask : send

  // ************************************************************
  // scenarios
  // ************************************************************
  // every column width and access width, row then column
  task automatic t_sdram();
    logic [25:0] wd;
    logic [3:0]  ln;
    logic [1:0]  bk;
    int          cb;
    for (int s = 0; s < 4; s++)
      for (int w = 0; w < 3; w++)
      begin
        col_bits_sel = 2'(s);
        bk = 2'(s + w);
        ln = 4'(5 + s * 3 + w);
        wd = A1 >> w;
        cb = 8 + s;
        send(mam_pkg::MAM_CYC_SDRAM, w, 1'b0, bk, A1, ln);
        check("row", addr, {bk, 7'h00, 13'(wd >> cb)});
        check("bank_hi", bhi, bk[1]);
        check("bank_lo", blo, bk[0]);
        check("lane_mask", mask, 4'(~ln));
        check("sd_busy", busy, 1'b0);
        send(mam_pkg::MAM_CYC_SDRAM, w, 1'b1, bk, A1, ln);
        check("col", addr, {bk, 7'h00, 13'(wd & ((26'h1 << cb) - 1))});
      end
  endtask : t_sdram

  // memory banks shift by width, io banks do not
  task automatic t_async();
    for (int w = 0; w < 3; w++)
    begin
      send(mam_pkg::MAM_CYC_MEM, w, 1'b0, 2'h3, A2, 4'h0);
      check("mem_addr", addr, 22'(A2 >> w));
      check("mem_busy", busy, 1'b1);
      check("mem_mask", mask, 4'hf);
      check("mem_wait", wact, 1'b0);
      send(mam_pkg::MAM_CYC_IO, w, 1'b0, 2'h3, A1, 4'h0);
      check("io_addr", addr, A1[21:0]);
    end
  endtask : t_async

  // wait low stretches the access and freezes the address
  task automatic t_wait();
    hold_wait = 1'b1;
    repeat (6) @(posedge clk);
    send(mam_pkg::MAM_CYC_MEM, 2, 1'b0, 2'h0, A2, 4'h0);
    repeat (4) @(posedge clk);
    #1 check("wait_busy", busy, 1'b1);
    check("wait_flag", wact, 1'b1);
    send(mam_pkg::MAM_CYC_IO, 0, 1'b0, 2'h0, A1, 4'h0);
    check("held_addr", addr, 22'(A2 >> 2));
    hold_wait = 1'b0;
    repeat (10)
      if (busy === 1'b1)
      begin
        @(posedge clk);
        #1;
      end
    check("released", busy, 1'b0);
    check("after_wait", addr, 22'(A2 >> 2));
  endtask : t_wait

  // clock out follows the system clock, sdram clock arrives
  task automatic t_clock();
    check("clk_hi", sys_clk, 1'b1);
    #12.5 check("clk_lo", sys_clk, 1'b0);
    check("sd_seen", seen, 1'b1);
  endtask : t_clock

  // ************************************************************
  // run control
  // ************************************************************
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    col_bits_sel = 2'h0;
    hold_wait = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    check("rst_addr", addr, 22'h00_0000);
    check("rst_mask", mask, 4'hf);
    check("rst_seen", seen, 1'b0);
    check("rst_busy", busy, 1'b0);
    t_sdram();
    t_async();
    t_wait();
    t_clock();
    give_verdict();
  end

  // hang guard, tests need under a hundred cycles
  initial
  begin
    #(25 * 4000);
    errors++;
    give_verdict();
  end
endmodule : testbench
